// File: design/energy_pkg.sv
package energy_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int STEP_CYCLES = 5;
    localparam int WAVE_BASE_SPS = 25_600;
    localparam int WAVE_BASE_CYCLES = CLK_HZ / WAVE_BASE_SPS;
    localparam int PULSE_LOW_NS = 1_000;
    localparam int PULSE_CYCLES = (PULSE_LOW_NS * (CLK_HZ / 1_000_000)
        + 999) / 1_000;
    localparam int ACC_W = 49;
    localparam logic [7:0] ADDR_LINE_VAR = 8'h06;
    localparam logic [7:0] ADDR_APP = 8'h07;
    localparam logic [7:0] ADDR_APP_RC = 8'h08;
    localparam logic [7:0] ADDR_WAVE = 8'h0d;
    localparam logic [7:0] ADDR_MODE = 8'h0f;
    localparam logic [7:0] ADDR_HALF_CYC = 8'h12;
    localparam logic [7:0] ADDR_APP_GAIN = 8'h1f;
    localparam logic [7:0] ADDR_APP_DIV = 8'h26;
    localparam logic [7:0] ADDR_IRQ_EN2 = 8'hda;
    localparam logic [7:0] ADDR_IRQ_EN3 = 8'hdb;
    localparam logic [7:0] ADDR_IRQ_ST3 = 8'hde;
    localparam logic [7:0] ADDR_APP_ST = 8'h40;
    localparam int MODE_SIGNED_BY_ACTIVE = 2;
    localparam int MODE_ABSOLUTE = 3;
    localparam int IRQ3_CYCLE_DONE = 2;
    localparam int IRQ3_WAVE_EN = 5;
    localparam int IRQ2_HALF_FULL = 2;
    localparam int IRQ2_OVERFLOW = 5;
    localparam int WAVE_RATE_LSB = 3;
    localparam logic [2:0] WAVE_SRC_APPARENT = 3'h4;
    localparam int GAIN_SHIFT = 12;
    localparam logic signed [25:0] PULSE_WEIGHT = 26'h080_0000;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_HALF_CYC = 16'h0000;
    localparam logic [11:0] RESET_GAIN = 12'h000;
endpackage

// File: design/energy_accum.sv
`timescale 1ns/1ns
`default_nettype none
module energy_accum (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic step,
    input wire logic signed [25:0] sample,
    input wire logic [7:0] divisor,
    input wire logic clear_all,
    input wire logic clear_upper,
    output logic [energy_pkg::ACC_W-1:0] acc,
    output logic half_evt,
    output logic ovf_evt
);
    import energy_pkg::*;

    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic signed [26:0] rem;
    } acc_state_t;

    acc_state_t s;
    acc_state_t next_s;
    logic signed [26:0] sum;
    logic signed [26:0] dd;
    logic signed [26:0] quo;
    logic [ACC_W-1:0] base;

    always_comb
    begin
        next_s = s;
        // remainder is carried so the quotient sum equals total over divisor
        sum = s.rem + 27'(sample);
        dd = (divisor == 8'h00) ? 27'sh000_0001
            : $signed({19'h0_0000, divisor});
        quo = sum / dd;
        base = clear_all ? '0 : s.acc;
        if (clear_upper)
        begin
            base = {24'h00_0000, s.acc[ACC_W-25:0]};
        end
        if (step)
        begin
            next_s.acc = base + ACC_W'(quo);
            next_s.rem = sum % dd;
        end
        else
        begin
            next_s.acc = base;
        end
        if (clear_all)
        begin
            next_s.rem = step ? next_s.rem : '0;
        end
        half_evt = step && !quo[26] && !base[ACC_W-1]
            && next_s.acc[ACC_W-1];
        ovf_evt = step && !quo[26] && base[ACC_W-1]
            && !next_s.acc[ACC_W-1];
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign acc = s.acc;
endmodule // energy_accum
`default_nettype wire

// File: design/energy_core.sv
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module energy_core (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [23:0] reg_rdata,
    input wire logic signed [23:0] reactive_power,
    input wire logic signed [23:0] active_power,
    input wire logic [23:0] reactive_noload_thr,
    input wire logic [11:0] vrms,
    input wire logic [11:0] irms,
    input wire logic zero_cross,
    output logic freq_pulse_out_n,
    output logic reactive_noload,
    output logic [23:0] wave_data,
    output logic wave_valid,
    output logic irq_pending
);
    import energy_pkg::*;

    typedef enum logic [0:0] {LINE_WAIT, LINE_RUN} line_t;

    typedef struct packed {
        logic [7:0] accumulation_mode_ctrl;
        logic [7:0] waveform_select;
        logic [15:0] half_cycle_count;
        logic [11:0] apparent_gain;
        logic [7:0] apparent_divider;
        logic [7:0] irq_enable_two;
        logic [7:0] irq_enable_three;
        logic [7:0] irq_status_three;
        logic [7:0] app_status;
        logic [23:0] line_reactive_energy;
        logic [23:0] rdata;
        logic [2:0] phase;
        line_t line_state;
        logic [15:0] hc_count;
        logic signed [25:0] pulse_acc;
        logic [7:0] pulse_cnt;
        logic [12:0] wave_cnt;
        logic [23:0] wave_data;
        logic wave_valid;
    } state_t;

    state_t s;
    state_t next_s;
    logic step;
    logic wr_half_cyc;
    logic line_clear;
    logic line_done;
    logic [23:0] ap;
    logic signed [36:0] gain_prod;
    logic signed [25:0] ap_gained;
    logic signed [24:0] rq;
    logic signed [24:0] mag;
    logic signed [24:0] eff;
    logic below;
    logic abs_mode;
    logic sav_mode;
    logic [ACC_W-1:0] app_acc;
    logic [ACC_W-1:0] line_acc;
    logic app_half;
    logic app_ovf;
    logic signed [25:0] pa;
    logic [12:0] wave_period;
    logic [23:0] rd_mux;

    assign step = (s.phase == 3'(STEP_CYCLES - 1));
    assign wr_half_cyc = reg_wr && (reg_addr == ADDR_HALF_CYC);
    assign abs_mode = s.accumulation_mode_ctrl[MODE_ABSOLUTE];
    assign sav_mode = s.accumulation_mode_ctrl[MODE_SIGNED_BY_ACTIVE];

    // product of the rms values; the apparent_gain term is added after it
    assign ap = vrms * irms;
    assign gain_prod = $signed({1'b0, ap}) * $signed(s.apparent_gain);
    assign ap_gained = $signed({2'b00, ap})
        + 26'(gain_prod >>> GAIN_SHIFT);

    always_comb
    begin
        rq = 25'(reactive_power);
        mag = (rq < 0) ? -rq : rq;
        below = mag < $signed({1'b0, reactive_noload_thr});
        // absolute is checked first: it wins when both bits are set
        if (abs_mode)
        begin
            eff = below ? 25'sh000_0000 : mag;
        end
        else if (sav_mode && active_power < 0)
        begin
            eff = -rq;
        end
        else
        begin
            eff = rq;
        end
    end

    // detection stays live whatever the mode
    assign reactive_noload = below;

    energy_accum app_accum (
        .sys_clk(sys_clk),
        .rst(rst),
        .step(step),
        .sample(ap_gained),
        .divisor(s.apparent_divider),
        .clear_all(1'b0),
        .clear_upper(reg_rd && reg_addr == ADDR_APP_RC),
        .acc(app_acc),
        .half_evt(app_half),
        .ovf_evt(app_ovf)
    );

    // same sample and weight as the reactive energy path
    energy_accum line_accum (
        .sys_clk(sys_clk),
        .rst(rst),
        .step(step && s.line_state == LINE_RUN),
        .sample(26'(eff)),
        .divisor(8'h00),
        .clear_all(line_clear),
        .clear_upper(1'b0),
        .acc(line_acc),
        .half_evt(),
        .ovf_evt()
    );

    always_comb
    begin
        unique case (reg_addr)
            ADDR_LINE_VAR: rd_mux = s.line_reactive_energy;
            ADDR_APP, ADDR_APP_RC: rd_mux = app_acc[ACC_W-1:ACC_W-24];
            ADDR_WAVE: rd_mux = {16'h0000, s.waveform_select};
            ADDR_MODE: rd_mux = {16'h0000, s.accumulation_mode_ctrl};
            ADDR_HALF_CYC: rd_mux = {8'h00, s.half_cycle_count};
            ADDR_APP_GAIN: rd_mux = {12'h000, s.apparent_gain};
            ADDR_APP_DIV: rd_mux = {16'h0000, s.apparent_divider};
            ADDR_IRQ_EN2: rd_mux = {16'h0000, s.irq_enable_two};
            ADDR_IRQ_EN3: rd_mux = {16'h0000, s.irq_enable_three};
            ADDR_IRQ_ST3: rd_mux = {16'h0000, s.irq_status_three};
            ADDR_APP_ST: rd_mux = {16'h0000, s.app_status};
            default: rd_mux = 24'h00_0000;
        endcase
    end

    always_comb
    begin
        next_s = s;
        line_clear = 1'b0;
        line_done = 1'b0;
        pa = s.pulse_acc;
        wave_period = 13'(WAVE_BASE_CYCLES)
            << s.waveform_select[WAVE_RATE_LSB +: 2];
        next_s.phase = step ? 3'h0 : s.phase + 3'h1;
        next_s.rdata = reg_rd ? rd_mux : 24'h00_0000;

        if (reg_wr)
        begin
            unique case (reg_addr)
                ADDR_WAVE: next_s.waveform_select = reg_wdata[7:0];
                ADDR_MODE: next_s.accumulation_mode_ctrl = reg_wdata[7:0];
                ADDR_HALF_CYC: next_s.half_cycle_count = reg_wdata;
                ADDR_APP_GAIN: next_s.apparent_gain = reg_wdata[11:0];
                ADDR_APP_DIV: next_s.apparent_divider = reg_wdata[7:0];
                ADDR_IRQ_EN2: next_s.irq_enable_two = reg_wdata[7:0];
                ADDR_IRQ_EN3: next_s.irq_enable_three = reg_wdata[7:0];
                ADDR_IRQ_ST3: next_s.irq_status_three =
                    s.irq_status_three & ~reg_wdata[7:0];
                ADDR_APP_ST: next_s.app_status =
                    s.app_status & ~reg_wdata[7:0];
                default: ;
            endcase
        end

        if (wr_half_cyc)
        begin
            next_s.line_reactive_energy = 24'h00_0000;
            next_s.line_state = LINE_WAIT;
            next_s.hc_count = 16'h0000;
            line_clear = 1'b1;
        end
        else
        begin
            unique case (s.line_state)
                LINE_WAIT:
                begin
                    if (zero_cross)
                    begin
                        next_s.line_state = LINE_RUN;
                        next_s.hc_count = 16'h0000;
                        line_clear = 1'b1;
                    end
                end
                LINE_RUN:
                begin
                    if (zero_cross)
                    begin
                        if (s.half_cycle_count != 16'h0000
                            && s.hc_count + 16'h0001 == s.half_cycle_count)
                        begin
                            line_done = 1'b1;
                            // unread result is simply replaced
                            next_s.line_reactive_energy =
                                line_acc[ACC_W-1:ACC_W-24];
                            next_s.hc_count = 16'h0000;
                            line_clear = 1'b1;
                        end
                        else
                        begin
                            next_s.hc_count = s.hc_count + 16'h0001;
                        end
                    end
                end
            endcase
        end

        // sets come after the clears so a same-cycle event survives
        if (line_done)
        begin
            next_s.irq_status_three[IRQ3_CYCLE_DONE] = 1'b1;
        end
        if (app_half)
        begin
            next_s.app_status[IRQ2_HALF_FULL] = 1'b1;
        end
        if (app_ovf)
        begin
            next_s.app_status[IRQ2_OVERFLOW] = 1'b1;
        end

        // a crossing during a running pulse is dropped: low width is fixed
        if (s.pulse_cnt != 8'h00)
        begin
            next_s.pulse_cnt = s.pulse_cnt - 8'h01;
        end
        if (step)
        begin
            pa = s.pulse_acc + 26'(eff);
            if (pa >= PULSE_WEIGHT || pa <= -PULSE_WEIGHT)
            begin
                pa = (pa < 0) ? pa + PULSE_WEIGHT : pa - PULSE_WEIGHT;
                if (s.pulse_cnt == 8'h00)
                begin
                    next_s.pulse_cnt = 8'(PULSE_CYCLES);
                end
            end
            next_s.pulse_acc = pa;
        end

        next_s.wave_valid = 1'b0;
        if (s.wave_cnt >= wave_period - 13'h0001)
        begin
            next_s.wave_cnt = 13'h0000;
            if (s.irq_enable_three[IRQ3_WAVE_EN]
                && s.waveform_select[2:0] == WAVE_SRC_APPARENT)
            begin
                next_s.wave_data = 24'(ap_gained);
                next_s.wave_valid = 1'b1;
            end
        end
        else
        begin
            next_s.wave_cnt = s.wave_cnt + 13'h0001;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s <= '0;
            s.accumulation_mode_ctrl <= RESET_BYTE;
            s.half_cycle_count <= RESET_HALF_CYC;
            s.apparent_gain <= RESET_GAIN;
            s.line_state <= LINE_WAIT;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign freq_pulse_out_n = (s.pulse_cnt == 8'h00);
    assign wave_data = s.wave_data;
    assign wave_valid = s.wave_valid;
    assign irq_pending = (s.irq_status_three[IRQ3_CYCLE_DONE]
        && s.irq_enable_three[IRQ3_CYCLE_DONE])
        || (s.app_status[IRQ2_HALF_FULL] && s.irq_enable_two[IRQ2_HALF_FULL])
        || (s.app_status[IRQ2_OVERFLOW]
        && s.irq_enable_two[IRQ2_OVERFLOW]);

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    chk_step_period: assert property (
        step |=> !step [*4] ##1 step)
        else $error("accumulation step spacing wrong");
    chk_sav_negate: assert property (
        sav_mode && !abs_mode && active_power < 0 |-> eff == -rq)
        else $error("signed-by-active sample not negated");
    chk_abs_noload: assert property (
        abs_mode && below |-> eff == 25'sh000_0000)
        else $error("absolute mode accumulated below no-load");
    chk_abs_magnitude: assert property (
        abs_mode && !below |-> eff == mag)
        else $error("absolute mode sample not magnitude");
    chk_gain_unity: assert property (
        s.apparent_gain == 12'h000 |-> ap_gained == $signed({2'b00, ap}))
        else $error("zero gain changed apparent power");
    chk_line_clear: assert property (
        wr_half_cyc |=> s.line_reactive_energy == 24'h00_0000
        && s.line_state == LINE_WAIT)
        else $error("half-cycle write did not clear line result");
    chk_cycle_done: assert property (
        line_done |=> s.irq_status_three[IRQ3_CYCLE_DONE]
        && s.line_state == LINE_RUN ##1 $stable(s.line_reactive_energy))
        else $error("cycle-done flag not raised");
    chk_irq_hold: assert property (
        s.irq_status_three[IRQ3_CYCLE_DONE]
        && s.irq_enable_three[IRQ3_CYCLE_DONE] |-> irq_pending)
        else $error("cycle-done interrupt not pending");
    chk_flag_hold: assert property (
        s.irq_status_three[IRQ3_CYCLE_DONE]
        && !(reg_wr && reg_addr == ADDR_IRQ_ST3
        && reg_wdata[IRQ3_CYCLE_DONE])
        |=> s.irq_status_three[IRQ3_CYCLE_DONE])
        else $error("cycle-done flag dropped without a clear");
    chk_read_clear: assert property (
        reg_rd && reg_addr == ADDR_APP_RC |=> app_acc[ACC_W-1:ACC_W-23] == '0
        && reg_rdata == $past(app_acc[ACC_W-1:ACC_W-24]))
        else $error("read-to-clear did not clear");
    chk_pulse_low: assert property (
        $fell(freq_pulse_out_n) |-> !freq_pulse_out_n [*8])
        else $error("reactive pulse too short");

    cov_line_done: cover property (line_done);
    cov_read_clear: cover property (reg_rd && reg_addr == ADDR_APP_RC);
    cov_pulse: cover property ($fell(freq_pulse_out_n) && abs_mode);
    cov_wave: cover property (wave_valid);
endmodule // energy_core
`default_nettype wire

// File: tb/line_source.sv
`timescale 1ns/1ns
`default_nettype none
module line_source #(
    parameter int HALF = 100
) (
    input wire logic sys_clk,
    input wire logic rst,
    output logic zero_cross
);
    int cnt;
    // fixed half period keeps every line run an exact number of steps
    always_ff @(posedge sys_clk)
    begin
        if (rst || cnt == HALF - 1)
        begin
            cnt <= 0;
        end
        else
        begin
            cnt <= cnt + 1;
        end
    end
    assign zero_cross = (cnt == HALF - 1);
endmodule // line_source
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import energy_pkg::*;
    localparam longint P = 16769025;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [23:0] reg_rdata;
    logic signed [23:0] reactive_power = 24'h00_0000;
    logic signed [23:0] active_power = 24'h00_0000;
    logic [23:0] reactive_noload_thr = 24'h00_0000;
    logic [11:0] vrms = 12'h000;
    logic [11:0] irms = 12'h000;
    logic zero_cross;
    logic freq_pulse_out_n;
    logic reactive_noload;
    logic [23:0] wave_data;
    logic wave_valid;
    logic irq_pending;
    int failures = 0;
    int num_checks = 0;
    logic [23:0] v;
    logic [23:0] c;
    longint e;
    longint t0;
    int k;
    logic [7:0] regs [8] = '{ADDR_MODE, ADDR_HALF_CYC, ADDR_APP_GAIN,
        ADDR_APP_DIV, ADDR_IRQ_EN2, ADDR_IRQ_EN3, ADDR_IRQ_ST3, 8'h55};
    logic [11:0] gains [3] = '{12'h000, 12'h7ff, 12'h801};
    logic [7:0] divs [3] = '{8'h00, 8'h00, 8'h03};
    logic [7:0] modes [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h08};
    logic [23:0] reacts [5] = '{24'h40_0000, 24'h40_0000, 24'hc0_0000,
        24'h40_0000, 24'h40_0000};
    logic [23:0] acts [5] = '{24'h00_0001, 24'hff_ffff, 24'h00_0001,
        24'hff_ffff, 24'h00_0001};
    logic [23:0] cens [5] = '{24'h00_0005, 24'hff_fffb, 24'h00_0005,
        24'h00_0005, 24'h00_0000};

    always #25 sys_clk = ~sys_clk;

    energy_core dut (
        .sys_clk(sys_clk),
        .rst(rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .reactive_power(reactive_power),
        .active_power(active_power),
        .reactive_noload_thr(reactive_noload_thr),
        .vrms(vrms),
        .irms(irms),
        .zero_cross(zero_cross),
        .freq_pulse_out_n(freq_pulse_out_n),
        .reactive_noload(reactive_noload),
        .wave_data(wave_data),
        .wave_valid(wave_valid),
        .irq_pending(irq_pending)
    );

    line_source src (
        .sys_clk(sys_clk),
        .rst(rst),
        .zero_cross(zero_cross)
    );

    task automatic conclude();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] lo,
        input logic [23:0] hi);
        num_checks++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [23:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // sel 0 waits on the interrupt line, sel 1 on a waveform sample
    task automatic wait_hi(input int sel, input int lim);
        logic s;
        for (int n = 0; n < lim; n++)
        begin
            @(posedge sys_clk);
            #1;
            s = (sel == 0) ? irq_pending : wave_valid;
            if (s === 1'b1)
            begin
                return;
            end
        end
        failures++;
        $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        conclude();
    endtask

    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (regs[i])
        begin
            rd(regs[i], v);
            chk(v, 24'h00_0000, 24'h00_0000);
        end
        wr(ADDR_HALF_CYC, 16'hffff);
        rd(ADDR_HALF_CYC, v);
        chk(v, 24'h00_ffff, 24'h00_ffff);
        wr(ADDR_APP, 16'h1234);
        rd(ADDR_APP, v);
        chk(v, 24'h00_0000, 24'h00_0000);
        @(posedge sys_clk);
        vrms <= 12'hfff;
        irms <= 12'hfff;
        for (int i = 0; i < 3; i++)
        begin
            wr(ADDR_APP_GAIN, {4'h0, gains[i]});
            wr(ADDR_APP_DIV, {8'h00, divs[i]});
            rd(ADDR_APP_RC, v);
            repeat (2000) @(posedge sys_clk);
            rd(ADDR_APP_RC, v);
            e = longint'($signed(gains[i]));
            e = 400 * P * (4096 + e) / 4096;
            e = e / ((divs[i] == 8'h00) ? 1 : divs[i]) / 33554432;
            chk(v, 24'(e - 2), 24'(e + 2));
            rd(ADDR_APP, v);
            chk(v, 24'h00_0000, 24'h00_0001);
        end
        wr(ADDR_APP_GAIN, 16'h0000);
        wr(ADDR_IRQ_EN3, 16'h0020);
        for (int r = 0; r < 4; r++)
        begin
            wr(ADDR_WAVE, {11'h000, 2'(r), 3'h4});
            wait_hi(1, 7000);
            chk(wave_data, 24'(P), 24'(P));
            t0 = $time;
            wait_hi(1, 7000);
            chk(24'(($time - t0) / 50), 24'(781 << r), 24'(781 << r));
        end
        wr(ADDR_IRQ_EN3, 16'h0004);
        for (int i = 0; i < 5; i++)
        begin
            @(posedge sys_clk);
            reactive_power <= reacts[i];
            active_power <= acts[i];
            reactive_noload_thr <= (i == 4) ? 24'h50_0000 : 24'h00_0000;
            c = cens[i];
            wr(ADDR_MODE, {8'h00, modes[i]});
            wr(ADDR_HALF_CYC, 16'h0002);
            wr(ADDR_IRQ_ST3, 16'h0004);
            rd(ADDR_LINE_VAR, v);
            chk(v, 24'h00_0000, 24'h00_0000);
            wait_hi(0, 400);
            rd(ADDR_LINE_VAR, v);
            chk(v, (i == 4) ? c : c - 1, (i == 4) ? c : c + 1);
            wr(ADDR_IRQ_ST3, 16'h0004);
            #1;
            chk({23'h00_0000, irq_pending}, 24'h00_0000, 24'h00_0000);
            k = 0;
            repeat (100)
            begin
                @(posedge sys_clk);
                #1;
                k = (freq_pulse_out_n === 1'b0) ? k + 1 : k;
            end
            chk(24'(k), (i == 4) ? 0 : 1, (i == 4) ? 0 : 100);
            chk({23'h00_0000, reactive_noload}, 24'(i == 4),
                24'(i == 4));
            wait_hi(0, 300);
            rd(ADDR_LINE_VAR, v);
            chk(v, (i == 4) ? c : c - 1, (i == 4) ? c : c + 1);
        end
        conclude();
    end
endmodule // tb_top
`default_nettype wire
